// ### logic/ctp_pkg.sv
// Constants and register map of the counter/timer pulse and waveform block
// How it works
// RULE1: Waveform period is sum of paired images
// RULE2: Host sets both load bits after image change
// RULE3: Enabled units run once start bit set
// RULE4: Pulse width equals image value in ticks
// RULE5: All four units do pulse, own outputs
// RULE6: Polarity bit one makes output active high
// RULE7: Trigger copies image into counter at once
// RULE8: Enable from pin, macrocell or software
// RULE9: Mode bit one selects pulse mode
// RULE10: Direction bit zero counts down to zero
// RULE11: Select bit one puts unit in operation
// RULE12: Source bit zero takes macrocell, not pin
// RULE13: Load source bit zero gives macrocell load; code loads on the selected input, the pin when source bit is one
// RULE14: Enable bit one gives continuous counting
// RULE15: Scale bit picks divide by one or eight
// RULE16: Start bit turns on all selected units
// RULE17: Global mode zero means waveform or pulse
// RULE18: Watchdog bit only touches unit two
// RULE19: Retrigger during pulse reloads full width
// RULE20: Macrocell rising edge loads then pulses
// RULE21: Port A bit zero routes timer output
// RULE22: Event rising edge increments count by one
// RULE23: Mode bit zero selects waveform mode
// RULE24: Terminal count reloads the partner unit
// RULE25: Software load bits clear on unit start
// RULE26: Pulse ends at zero, waits for trigger
package ctp_pkg;
    // Register offsets inside the I/O chip-select window
    localparam logic [3:0] OFS_CMD0       = 4'h0;  // Unit commands at 0..3
    localparam logic [3:0] OFS_IMAGE_REG_ZERO       = 4'h4;  // Image registers at 4..7
    localparam logic [3:0] OFS_SW_LOAD    = 4'h8;  // Software load/store bits
    localparam logic [3:0] OFS_GLOBAL     = 4'h9;  // Global control
    localparam logic [3:0] OFS_PORT_A_ALT = 4'hA;  // Port A alternate function
    localparam logic [3:0] OFS_CNT0       = 4'hC;  // Counter read back at C..F

    // Unit command field positions
    localparam int CMD_MODE   = 0;  // 1 pulse, 0 waveform
    localparam int CMD_DIR    = 1;  // 0 down, 1 up
    localparam int CMD_SEL    = 2;  // Unit selected
    localparam int CMD_OPOL   = 3;  // Output active high when 1
    localparam int CMD_IPOL   = 4;  // Pin input active high when 1
    localparam int CMD_SRC    = 5;  // 1 pin, 0 macrocell
    localparam int CMD_LDSRC  = 6;  // 1 software load, 0 input load
    localparam int CMD_EN     = 7;  // 1 always enabled

    // Global control field positions
    localparam int GLB_SCALE  = 0;  // Divide by eight when 1
    localparam int GLB_START  = 1;  // Start selected units
    localparam int GLB_MODE   = 2;  // 1 event/capture group
    localparam int GLB_WDOG   = 3;  // Watchdog on unit two

    // Port A alternate function bit
    localparam int ALT_TIMER_OUT = 0;

    // Reset values
    localparam logic [7:0] RST_CMD    = 8'h00;
    localparam logic [7:0] RST_IMAGE  = 8'h00;
    localparam logic [7:0] RST_GLOBAL = 8'h00;
    localparam logic [7:0] RST_ALT    = 8'h00;

    // Prescaler divide ratio of the scaled setting
    localparam logic [2:0] PRESCALE_LAST = 3'h7;  // Eight clocks per tick
    localparam int         WATCHDOG_UNIT = 2;
endpackage

// ### logic/ctp_top.sv
// Four counter/timer units with waveform, pulse and event counting
`timescale 1ns/10ps
`default_nettype none

module ctp_top #(
    parameter int UNITS = 4,      // Counter/timer units, paired for waveform
    parameter int CW    = 8       // Counter and image width
) (
    input  wire logic              clock,
    input  wire logic              srst,
    input  wire logic              io_chip_select_window,
    input  wire logic [3:0]        reg_addr,
    input  wire logic              reg_write,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata,
    input  wire logic [UNITS-1:0]  port_e_inputs,
    input  wire logic [UNITS-1:0]  macrocell_triggers,
    output logic      [UNITS-1:0]  unit_outputs,
    output logic      [UNITS/2-1:0] pair_waveform,
    output logic                   default_timer_output,
    output logic                   port_a_pin_zero,
    output logic                   port_a_pin_zero_oe_n,
    output logic                   watchdog_expired
);

    // Register file
    logic [7:0]    timer_unit_command [UNITS];  // Per-unit command
    logic [CW-1:0] image_reg [UNITS];           // Per-unit image value
    logic [UNITS-1:0] sw_load;                  // Software load/store bits
    logic [7:0]    timer_global_control;        // Global command
    logic [7:0]    port_a_alt_function;         // Port A special function

    // Unit state
    logic [CW-1:0] count [UNITS];               // Live counter
    logic [UNITS-1:0] busy;                     // Unit counting down
    logic [UNITS-1:0] src_q;                    // Previous trigger input
    logic [UNITS-1:0] term_count;               // Terminal count this cycle
    logic [UNITS-1:0] unit_start;               // Unit took a software load
    logic [2:0]    prescale;                    // Prescaler phase
    logic          tick;                        // Timer clock enable

    // Register write strobe
    logic wr_en;
    assign wr_en = io_chip_select_window & reg_write;

    // Global shorthands
    logic g_start;
    logic g_event;
    // RULE16: start gates all selected units
    assign g_start = timer_global_control[ctp_pkg::GLB_START];
    // RULE17: zero keeps waveform/pulse group
    assign g_event = timer_global_control[ctp_pkg::GLB_MODE];

    // Prescaler phase counter
    always_ff @(posedge clock) begin
        if (srst) begin
            prescale <= 3'h0;
        end else begin
            prescale <= prescale + 3'h1;
        end
    end

    // RULE15: divide by one or by eight
    assign tick = ~timer_global_control[ctp_pkg::GLB_SCALE] |
                  (prescale == ctp_pkg::PRESCALE_LAST);

    // Command and image register writes
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int k = 0; k < UNITS; k++) begin
                timer_unit_command[k] <= ctp_pkg::RST_CMD;
                image_reg[k]          <= CW'(ctp_pkg::RST_IMAGE);
            end
        end else if (wr_en) begin
            for (int k = 0; k < UNITS; k++) begin
                // Command register of unit k
                if (reg_addr == ctp_pkg::OFS_CMD0 + 4'(k)) begin
                    timer_unit_command[k] <= reg_wdata;
                end
                // Image register of unit k
                if (reg_addr == ctp_pkg::OFS_IMAGE_REG_ZERO + 4'(k)) begin
                    image_reg[k] <= CW'(reg_wdata);
                end
            end
        end
    end

    // Global and port A registers
    always_ff @(posedge clock) begin
        if (srst) begin
            timer_global_control <= ctp_pkg::RST_GLOBAL;
            port_a_alt_function  <= ctp_pkg::RST_ALT;
        end else if (wr_en) begin
            // Global control word
            if (reg_addr == ctp_pkg::OFS_GLOBAL) begin
                timer_global_control <= reg_wdata;
            end
            // Port A alternate function word
            if (reg_addr == ctp_pkg::OFS_PORT_A_ALT) begin
                port_a_alt_function <= reg_wdata;
            end
        end
    end

    // Software load bits, a new write wins over the clear
    always_ff @(posedge clock) begin
        if (srst) begin
            sw_load <= '0;
        end else begin
            // RULE25: clear on start, set wins
            if (wr_en && reg_addr == ctp_pkg::OFS_SW_LOAD) begin
                sw_load <= (sw_load & ~unit_start) | reg_wdata[UNITS-1:0];
            end else begin
                sw_load <= sw_load & ~unit_start;
            end
        end
    end

    // RULE5: one identical unit per index
    for (genvar i = 0; i < UNITS; i++) begin : g_unit
        localparam int PARTNER = i ^ 1;         // Waveform partner
        logic [7:0] cmd;                        // Command shorthand
        logic       src;                        // Selected control input
        logic       rise;                       // Rising edge of input
        logic       run;                        // Unit on
        logic       wave;                       // Waveform mode
        logic       load;                       // Reload from image
        logic       own_load;                   // Reload from software or input

        assign cmd = timer_unit_command[i];

        // RULE12: pin or macrocell input
        // RULE8: pin, macrocell or software
        assign src = cmd[ctp_pkg::CMD_SRC] ?
                     (port_e_inputs[i] ~^ cmd[ctp_pkg::CMD_IPOL]) :
                     macrocell_triggers[i];
        assign rise = src & ~src_q[i];

        // RULE11: select bit gates unit
        // RULE14: continuous enable or input
        assign run = cmd[ctp_pkg::CMD_SEL] & g_start &
                     (cmd[ctp_pkg::CMD_EN] | src);

        // RULE23: mode zero is waveform
        // RULE9: mode one is pulse
        assign wave = ~cmd[ctp_pkg::CMD_MODE];

        // Local load sources, kept apart from the partner path
        // so the two terminal counts never form a combinational loop
        always_comb begin
            own_load = 1'b0;
            if (run && !g_event && !cmd[ctp_pkg::CMD_DIR]) begin
                // RULE13: input or software load
                // RULE2: host software load relied on
                if (cmd[ctp_pkg::CMD_LDSRC]) begin
                    own_load = sw_load[i];
                end else begin
                    // RULE20: load on rising edge
                    own_load = rise;
                end
            end
        end

        // Reload from local source or partner terminal count
        always_comb begin
            load = own_load;
            // RULE24: partner terminal count reloads
            if (run && !g_event && !cmd[ctp_pkg::CMD_DIR] && wave &&
                term_count[PARTNER]) begin
                load = 1'b1;
            end
        end

        // Terminal count on the last tick of a run
        assign term_count[i] = busy[i] & tick & ~own_load &
                               (count[i] == CW'(1));
        assign unit_start[i] = run & sw_load[i];

        // Input edge history
        always_ff @(posedge clock) begin
            if (srst) begin
                src_q[i] <= 1'b0;
            end else begin
                src_q[i] <= src;
            end
        end

        // Counter and busy flag
        always_ff @(posedge clock) begin
            if (srst) begin
                count[i] <= '0;
                busy[i]  <= 1'b0;
            end else if (g_event) begin
                busy[i] <= 1'b0;
                // RULE22: event edge adds one
                if (cmd[ctp_pkg::CMD_SEL] && g_start &&
                    cmd[ctp_pkg::CMD_DIR] && rise) begin
                    count[i] <= count[i] + CW'(1);
                end
            end else if (!g_start || !cmd[ctp_pkg::CMD_SEL]) begin
                // Stopped units stay idle
                busy[i] <= 1'b0;
            end else if (load) begin
                // RULE7: image copied at once
                // RULE19: retrigger reloads full width
                count[i] <= image_reg[i];
                busy[i]  <= (image_reg[i] != '0);
            end else if (busy[i] && tick && !cmd[ctp_pkg::CMD_DIR]) begin
                // RULE10: count down to zero
                // RULE4: width is image in ticks
                count[i] <= count[i] - CW'(1);
                // RULE26: zero ends pulse, waits
                if (count[i] == CW'(1)) begin
                    busy[i] <= 1'b0;
                end
            end
        end

        // Unit output with programmed polarity
        always_ff @(posedge clock) begin
            if (srst) begin
                unit_outputs[i] <= 1'b0;
            end else begin
                // RULE6: polarity one is active high
                unit_outputs[i] <= cmd[ctp_pkg::CMD_OPOL] ? busy[i] : ~busy[i];
            end
        end
    end

    // Pair waveform combines both halves of a pair
    for (genvar p = 0; p < UNITS / 2; p++) begin : g_pair
        always_ff @(posedge clock) begin
            if (srst) begin
                pair_waveform[p] <= 1'b0;
            end else begin
                // RULE1: period is sum of both images
                // RULE3: pair output lags start by three clocks (busy, unit output, pair register)
                pair_waveform[p] <= unit_outputs[2*p] & unit_outputs[2*p+1];
            end
        end
    end

    // Default timer output: pair zero in waveform, else unit zero
    always_ff @(posedge clock) begin
        if (srst) begin
            default_timer_output <= 1'b0;
        end else if (!timer_unit_command[0][ctp_pkg::CMD_MODE]) begin
            default_timer_output <= pair_waveform[0];
        end else begin
            default_timer_output <= unit_outputs[0];
        end
    end

    // Port A pin zero drive
    always_ff @(posedge clock) begin
        if (srst) begin
            port_a_pin_zero      <= 1'b0;
            port_a_pin_zero_oe_n <= 1'b1;
        end else begin
            // RULE21: bit zero routes timer out
            port_a_pin_zero      <= default_timer_output;
            port_a_pin_zero_oe_n <= ~port_a_alt_function[ctp_pkg::ALT_TIMER_OUT];
        end
    end

    // Watchdog expiry pulse
    always_ff @(posedge clock) begin
        if (srst) begin
            watchdog_expired <= 1'b0;
        end else begin
            // RULE18: only unit two, off at zero
            watchdog_expired <= timer_global_control[ctp_pkg::GLB_WDOG] &
                                term_count[ctp_pkg::WATCHDOG_UNIT];
        end
    end

    // Registered read data
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= 8'h00;
            for (int k = 0; k < UNITS; k++) begin
                // Command, image and counter of unit k
                if (reg_addr == ctp_pkg::OFS_CMD0 + 4'(k)) begin
                    reg_rdata <= timer_unit_command[k];
                end
                if (reg_addr == ctp_pkg::OFS_IMAGE_REG_ZERO + 4'(k)) begin
                    reg_rdata <= 8'(image_reg[k]);
                end
                if (reg_addr == ctp_pkg::OFS_CNT0 + 4'(k)) begin
                    reg_rdata <= 8'(count[k]);
                end
            end
            // Single registers
            if (reg_addr == ctp_pkg::OFS_SW_LOAD) begin
                reg_rdata <= 8'(sw_load);
            end
            if (reg_addr == ctp_pkg::OFS_GLOBAL) begin
                reg_rdata <= timer_global_control;
            end
            if (reg_addr == ctp_pkg::OFS_PORT_A_ALT) begin
                reg_rdata <= port_a_alt_function;
            end
        end
    end

endmodule

`default_nettype wire

// ### testbench/ctp_checker.sv
// Port checker for the counter/timer block
`timescale 1ns/10ps
`default_nettype none
module ctp_checker #(
    parameter int UNITS = 4,
    parameter int CW    = 8
) (
    input wire logic               clock,
    input wire logic               srst,
    input wire logic               io_chip_select_window,
    input wire logic [3:0]         reg_addr,
    input wire logic               reg_write,
    input wire logic [7:0]         reg_wdata,
    input wire logic [7:0]         reg_rdata,
    input wire logic [UNITS-1:0]   unit_outputs,
    input wire logic [UNITS/2-1:0] pair_waveform,
    input wire logic               default_timer_output,
    input wire logic               port_a_pin_zero,
    input wire logic               port_a_pin_zero_oe_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // Accepted write strobe
    wire logic wr;
    assign wr = io_chip_select_window && reg_write;
    property p_alt_on;
        wr && reg_addr == 4'hA && reg_wdata[0] |-> ##[1:2] !port_a_pin_zero_oe_n;
    endproperty
    a_alt_on: assert property (p_alt_on) else $error("pin not driven");
    property p_pin_delay;
        port_a_pin_zero == $past(default_timer_output);
    endproperty
    a_pin_delay: assert property (p_pin_delay) else $error("pin lag");
    property p_pair_and;
        pair_waveform == {&$past(unit_outputs[3:2]), &$past(unit_outputs[1:0])};
    endproperty
    a_pair_and: assert property (p_pair_and) else $error("pair wrong");
    property p_unmapped;
        reg_addr == 4'hB |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("hole read");
    property p_reset;
        @(posedge clock) disable iff (1'b0)
        srst |=> port_a_pin_zero_oe_n && unit_outputs == '0 && reg_rdata == 8'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state");
    property p_readback;
        wr && reg_addr != 4'h8 && reg_addr <= 4'hA ##1
        reg_addr == $past(reg_addr) && !wr |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("readback");
    property p_dto_src;
        default_timer_output == $past(unit_outputs[0])
        || default_timer_output == $past(pair_waveform[0]);
    endproperty
    a_dto_src: assert property (p_dto_src) else $error("timer out src");
    // Reset value first, then idle level of active-low default polarity
    property p_quiet;
        $fell(srst) |-> unit_outputs == '0 ##1 unit_outputs == '1;
    endproperty
    a_quiet: assert property (p_quiet) else $error("early output");
    c_pulse: cover property ($rose(unit_outputs[0]));
    c_wave: cover property ($rose(pair_waveform[0]));
    c_pin: cover property (!port_a_pin_zero_oe_n);
endmodule
`default_nettype wire

// ### testbench/ctp_host.sv
// Host model writing and reading the block registers
`timescale 1ns/10ps
`default_nettype none
module ctp_host (
    input  wire logic       clock,
    input  wire logic [7:0] reg_rdata,
    output logic            sel,
    output logic [3:0]      addr,
    output logic            write,
    output logic [7:0]      wdata
);
    // Idle bus at time zero
    initial begin
        sel = 1'b0;
        addr = 4'h0;
        write = 1'b0;
        wdata = 8'h00;
    end
    // One write, taken at the next edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        sel <= 1'b1;
        write <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        sel <= 1'b0;
        write <= 1'b0;
        wdata <= ~d;
    endtask
    // Address held, data one cycle later
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        @(posedge clock);
        @(posedge clock);
        d = reg_rdata;
    endtask
    task automatic wave_load();
        wr(4'h8, 8'h03);
    endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the counter/timer block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic       clock;
    logic       srst;
    logic [3:0] pe;      // Pin inputs
    logic [3:0] mc;      // Macrocell inputs
    logic [7:0] rdata;
    logic       sel;
    logic [3:0] addr;
    logic       write;
    logic [7:0] wdata;
    logic [3:0] outs;
    logic [1:0] pair;
    logic       dto;
    logic       pin;
    logic       pin_oe_n;
    logic       wdog;    // Watchdog expiry pulse
    logic [7:0] v;
    int fails = 0;
    int check_count = 0;
    int wd_cnt = 0;
    int cyc = 0;
    int n;
    int r;
    ctp_top dut (.clock(clock), .srst(srst), .io_chip_select_window(sel),
        .reg_addr(addr), .reg_write(write), .reg_wdata(wdata), .reg_rdata(rdata),
        .port_e_inputs(pe), .macrocell_triggers(mc), .unit_outputs(outs),
        .pair_waveform(pair), .default_timer_output(dto), .port_a_pin_zero(pin),
        .port_a_pin_zero_oe_n(pin_oe_n), .watchdog_expired(wdog));
    ctp_host host (.clock(clock), .reg_rdata(rdata), .sel(sel), .addr(addr),
        .write(write), .wdata(wdata));
    // Clock of 10 ns
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Count watchdog expiry pulses
    always @(posedge clock) begin
        if (wdog === 1'b1) wd_cnt++;
    end
    // Hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %0t value %h not %h", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            fails++;
            $display("unexpected %0t count %0d", $time, got);
        end
    endtask
    task automatic do_reset();
        srst <= 1'b1;
        pe <= 4'h0;
        mc <= 4'h0;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
    endtask
    // Trigger unit k by pin or macrocell, retrigger after g, count active cycles
    task automatic fire(input int k, input logic use_pin, input logic act,
                        input int g, output int cnt);
        cnt = 0;
        if (use_pin) pe[k] <= 1'b1;
        else mc[k] <= 1'b1;
        for (int i = 0; i < 60; i++) begin
            @(posedge clock);
            if (i == 0 || (g > 0 && i == g)) begin
                pe[k] <= 1'b0;
                mc[k] <= 1'b0;
            end else if (g > 0 && i == g - 1) begin
                if (use_pin) pe[k] <= 1'b1;
                else mc[k] <= 1'b1;
            end
            if (outs[k] === act) cnt++;
        end
    endtask
    task automatic t_regs();
        for (int a = 0; a < 12; a++) begin
            host.rd(a[3:0], v);
            chk8(v, 8'h00);
        end
        host.wr(4'hB, 8'h77);
        host.rd(4'hB, v);
        chk8(v, 8'h00);
        host.wr(4'h4, 8'h5A);
        host.rd(4'h4, v);
        chk8(v, 8'h5A);
        chk8({7'h0, pin_oe_n}, 8'h01);
    endtask
    task automatic t_pulse();
        do_reset();
        for (int k = 0; k < 4; k++) begin
            host.wr(k[3:0], k[0] ? 8'h95 : 8'h9D);
            host.wr(4'h4 + k[3:0], 8'h03);
        end
        host.wr(4'hA, 8'h01);
        host.wr(4'h9, 8'h02);
        for (int k = 0; k < 4; k++) begin
            fire(k, 1'b0, ~k[0], 0, n);
            chkn(n, 3, 3);
        end
        chkn(wd_cnt, 0, 0);
        fire(0, 1'b0, 1'b1, 2, n);
        chkn(n, 5, 5);
        fire(0, 1'b1, 1'b1, 0, n);
        chkn(n, 0, 0);
        chk8({7'h0, pin_oe_n}, 8'h00);
        host.wr(4'h9, 8'h0A);
        fire(2, 1'b0, 1'b1, 0, n);
        chkn(n, 3, 3);
        chkn(wd_cnt, 1, 1);
    endtask
    task automatic t_wave();
        do_reset();
        host.wr(4'h0, 8'hD4);
        host.wr(4'h1, 8'hCC);
        host.wr(4'h4, 8'h04);
        host.wr(4'h5, 8'h02);
        host.wave_load();
        host.wr(4'h9, 8'h02);
        host.rd(4'h8, v);
        chk8(v, 8'h00);
        repeat (10) @(posedge clock);
        n = 0;
        r = 0;
        for (int i = 0; i < 12; i++) begin
            @(posedge clock);
            if (pair[0] === 1'b1) n++;
            if (pair[0] === 1'b1 && i > 0 && v[0] === 1'b0) r++;
            v[0] = pair[0];
        end
        chkn(n, 4, 4);
        chkn(r, 2, 2);
    endtask
    task automatic t_scale();
        do_reset();
        host.wr(4'h0, 8'hBD);
        host.wr(4'h4, 8'h03);
        host.wr(4'h9, 8'h03);
        fire(0, 1'b1, 1'b1, 0, n);
        chkn(n, 17, 24);
    endtask
    task automatic t_event();
        do_reset();
        host.wr(4'h0, 8'h1E);
        host.wr(4'h9, 8'h06);
        repeat (3) begin
            mc[0] <= 1'b1;
            repeat (2) @(posedge clock);
            mc[0] <= 1'b0;
            repeat (2) @(posedge clock);
        end
        host.rd(4'hC, v);
        chk8(v, 8'h03);
    endtask
    task automatic stop_test();
        if (fails == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        srst = 1'b1;
        pe = 4'h0;
        mc = 4'h0;
        do_reset();
        t_regs();
        t_pulse();
        t_wave();
        t_scale();
        t_event();
        stop_test();
    end
endmodule
bind ctp_top ctp_checker #(.UNITS(UNITS), .CW(CW)) u_chk (.clock(clock), .srst(srst),
    .io_chip_select_window(io_chip_select_window), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .unit_outputs(unit_outputs), .pair_waveform(pair_waveform),
    .default_timer_output(default_timer_output), .port_a_pin_zero(port_a_pin_zero),
    .port_a_pin_zero_oe_n(port_a_pin_zero_oe_n));
`default_nettype wire
